// *** src/tcr_timer.sv ***
// reloadable 16-bit timer/counter with AHB-Lite register slave
`timescale 1ns/100ps
// Operation
// - 16-bit up-counter: timer, gated timer, event counter
// - timer counts each machine cycle, or every second
// - gated timer counts only while gate pin high
// - event count on sampled high-then-low gate pin
// - rollover sets overflow flag, request bit six
// - both flags share vector; software clears overflow
// - input select: stop, timer, counter, gated
// - reload select: off, on overflow, on trigger
// - overflow reload replaces zero same machine cycle
// - trigger falling edge reloads counter next cycle
// - trigger edge sets reload flag when enabled
// - compare mode bit picks compare mode one/zero
// - capture count on chosen channel-0 edge
// - prescale affects only timer and gated timer
//
// the counter and all registers live in one state struct; one comb
// process builds the next value and one flop process stores it
// machine cycle: a divider makes a one-cycle tick every MC_DIV clocks;
// pins are sampled only on that tick, after a two-flop synchroniser
// prescale: a toggle flips on every tick, so with prescale set the
// timer and gated timer advance on every second tick only
// event counter: a high sample followed by a low sample adds one; the
// source must hold each level for a whole tick or it may be lost
// overflow: a rollover sets the overflow flag and, with reload on
// overflow, loads the reload value instead of zero in the same tick
// trigger reload: a high-then-low trigger sample arms a pending load,
// which copies the reload value at the following tick; it wins over
// an overflow reload that lands in that same tick
// capture: the selected channel-0 edge copies the live count into the
// reload register and sets the capture status bit
// flags: hardware sets win over a software clear in the same cycle;
// the overflow flag is cleared only by software, never by hardware
// bus: zero wait states; read data is fetched at the address phase so
// hrdata comes from a flop, which means a read issued in the data
// phase of a write to the same register still sees the old value
// count bytes: the 16-bit count is reached as two separate bytes with
// no latch between them, so software must allow for a carry between
// reading the low and the high byte
// limitation: compare outputs are not built; compare_mode only shows
// the selected mode for logic outside this block
// hazard: levels on the pins shorter than one tick may be missed
module tcr_timer #(
  parameter int unsigned MC_DIV = tcr_pkg::MC_DIV
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire tcr_pkg::tcr_pins_t pins,
  output logic compare_mode,
  output logic irq
);
  // current and next state
  tcr_pkg::tcr_st_t s;
  tcr_pkg::tcr_st_t next_s;
  // one-cycle machine cycle enable
  logic mc;
  // counter increment this cycle
  logic inc;
  // trigger and channel-0 edges seen at a machine cycle
  logic t_fall;
  logic cap_ev;
  // events that set sticky flags
  logic ev_ovf;
  logic ev_xrl;
  logic [7:0] wd;

  // register byte read view; live count for the count bytes
  function automatic logic [7:0] rd_byte(input tcr_pkg::tcr_st_t q,
                                         input logic [7:0] i);
    case (i)
      tcr_pkg::IDX_IRQC: rd_byte = q.irqc;
      tcr_pkg::IDX_CCAP: rd_byte = q.ccap;
      tcr_pkg::IDX_CC1L: rd_byte = q.cc1[7:0];
      tcr_pkg::IDX_CC1H: rd_byte = q.cc1[15:8];
      tcr_pkg::IDX_CC2L: rd_byte = q.cc2[7:0];
      tcr_pkg::IDX_CC2H: rd_byte = q.cc2[15:8];
      tcr_pkg::IDX_CC3L: rd_byte = q.cc3[7:0];
      tcr_pkg::IDX_CC3H: rd_byte = q.cc3[15:8];
      tcr_pkg::IDX_CTL: rd_byte = q.ctl;
      tcr_pkg::IDX_RLDL: rd_byte = q.rld[7:0];
      tcr_pkg::IDX_RLDH: rd_byte = q.rld[15:8];
      tcr_pkg::IDX_CNTL: rd_byte = q.cnt[7:0];
      tcr_pkg::IDX_CNTH: rd_byte = q.cnt[15:8];
      tcr_pkg::IDX_IENB: rd_byte = q.ienb;
      tcr_pkg::IDX_STAT: rd_byte = {5'h0_0, q.sts};
      tcr_pkg::IDX_IEN: rd_byte = {5'h0_0, q.ien};
      // clear register is write-only; unmapped reads give zero
      default: rd_byte = tcr_pkg::RST_BYTE;
    endcase
  endfunction

  // zero-wait slave: always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign compare_mode = s.ctl[tcr_pkg::CTL_CM];
  // one level line for all enabled sticky events
  assign irq = |(s.sts & s.ien);
  assign wd = hwdata[7:0];
  assign mc = (s.div == tcr_pkg::DIV_W'(MC_DIV - 1));

  // increment decode by input select; prescale only in timer modes
  always_comb begin
    case ({s.ctl[tcr_pkg::CTL_IS_HI], s.ctl[tcr_pkg::CTL_IS_LO]})
      2'h1: inc = mc && (!s.ctl[tcr_pkg::CTL_PS] || s.pre);
      2'h3: inc = mc && s.g_smp &&
                  (!s.ctl[tcr_pkg::CTL_PS] || s.pre);
      // prescale ignored here; software keeps it clear
      2'h2: inc = mc && s.g_prv && !s.g_smp;
      default: inc = 1'b0;
    endcase
  end

  // edge detect on machine-cycle samples, never on the first sync flop
  assign t_fall = mc && s.t_prv && !s.t_smp &&
                  s.ctl[tcr_pkg::CTL_RS_HI] &&
                  s.ctl[tcr_pkg::CTL_RS_LO];
  assign cap_ev = mc && (s.ccap[1:0] == tcr_pkg::CAP_SEL) &&
                  (s.ctl[tcr_pkg::CTL_EDGE] ?
                   (!s.c_prv && s.c_smp) :
                   (s.c_prv && !s.c_smp));
  assign ev_ovf = inc && (s.cnt == tcr_pkg::CNT_MAX);
  assign ev_xrl = t_fall && s.ienb[tcr_pkg::IENB_XEN];

  // next-state logic: counter, samplers, bus, flags
  always_comb begin
    next_s = s;
    // machine cycle divider and 2:1 prescale toggle
    next_s.div = mc ? '0 : s.div + tcr_pkg::DIV_W'(1);
    if (mc) begin
      next_s.pre = ~s.pre;
    end
    // two-flop synchronisers for the three pins
    next_s.g_sync = {s.g_sync[0], pins.gate};
    next_s.t_sync = {s.t_sync[0], pins.trig};
    next_s.c_sync = {s.c_sync[0], pins.ch0};
    // pins sampled once per machine cycle
    if (mc) begin
      next_s.g_smp = s.g_sync[1];
      next_s.g_prv = s.g_smp;
      next_s.t_smp = s.t_sync[1];
      next_s.t_prv = s.t_smp;
      next_s.c_smp = s.c_sync[1];
      next_s.c_prv = s.c_smp;
    end
    // count up; on rollover reload or wrap to zero
    if (inc) begin
      if (s.cnt == tcr_pkg::CNT_MAX) begin
        if (s.ctl[tcr_pkg::CTL_RS_HI] &&
            !s.ctl[tcr_pkg::CTL_RS_LO]) begin
          next_s.cnt = s.rld;
        end else begin
          next_s.cnt = '0;
        end
      end else begin
        next_s.cnt = s.cnt + 16'h0001;
      end
    end
    // trigger reload lands one machine cycle after detection
    if (mc && s.ld_pend) begin
      next_s.cnt = s.rld;
      next_s.ld_pend = 1'b0;
    end
    if (t_fall) begin
      next_s.ld_pend = 1'b1;
    end
    // capture copies the live count into the reload register
    if (cap_ev) begin
      next_s.rld = s.cnt;
    end
    // data phase write; software write beats hardware count update
    if (s.aw) begin
      case (s.aidx)
        tcr_pkg::IDX_IRQC: next_s.irqc = wd;
        tcr_pkg::IDX_CCAP: next_s.ccap = wd;
        tcr_pkg::IDX_CC1L: next_s.cc1[7:0] = wd;
        tcr_pkg::IDX_CC1H: next_s.cc1[15:8] = wd;
        tcr_pkg::IDX_CC2L: next_s.cc2[7:0] = wd;
        tcr_pkg::IDX_CC2H: next_s.cc2[15:8] = wd;
        tcr_pkg::IDX_CC3L: next_s.cc3[7:0] = wd;
        tcr_pkg::IDX_CC3H: next_s.cc3[15:8] = wd;
        tcr_pkg::IDX_CTL: next_s.ctl = wd;
        tcr_pkg::IDX_RLDL: next_s.rld[7:0] = wd;
        tcr_pkg::IDX_RLDH: next_s.rld[15:8] = wd;
        tcr_pkg::IDX_CNTL: next_s.cnt[7:0] = wd;
        tcr_pkg::IDX_CNTH: next_s.cnt[15:8] = wd;
        tcr_pkg::IDX_IENB: next_s.ienb = wd;
        tcr_pkg::IDX_ICLR: next_s.sts = s.sts & ~wd[2:0];
        tcr_pkg::IDX_IEN: next_s.ien = wd[2:0];
        // status is read-only; other addresses ignore writes
        default: next_s.sts = next_s.sts;
      endcase
    end
    // hardware sets win over a clear in the same cycle; the
    // overflow flag is only ever cleared by software
    if (ev_ovf) begin
      next_s.irqc[tcr_pkg::IRC_OVF] = 1'b1;
      next_s.sts[tcr_pkg::ST_OVF] = 1'b1;
    end
    if (ev_xrl) begin
      next_s.irqc[tcr_pkg::IRC_XRL] = 1'b1;
      next_s.sts[tcr_pkg::ST_XRL] = 1'b1;
    end
    if (cap_ev) begin
      next_s.sts[tcr_pkg::ST_CAP] = 1'b1;
    end
    // address phase: latch writes, fetch read data now so hrdata
    // comes from a flop; a read right after a write to the same
    // register returns the value before that write
    next_s.aw = 1'b0;
    if (hsel && htrans[1] && hready) begin
      next_s.aw = hwrite;
      next_s.aidx = haddr[9:2];
      if (!hwrite) begin
        next_s.rdata = {24'h00_0000, rd_byte(s, haddr[9:2])};
      end
    end
  end

  // the one state register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // checks: one clock domain, so one default clocking and disable
  // serve all of them; most guards leave out a bus write or a pending
  // trigger reload in the same cycle, since both override the counter
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // machine cycle tick every MC_DIV cycles
  logic [7:0] mc_gap;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mc_gap <= '0;
    end else begin
      mc_gap <= mc ? 8'h00 : mc_gap + 8'h01;
    end
  end

  // the tick comes every MC_DIV core clocks, never early or late
  a_mc_period: assert property (
    mc |-> mc_gap == 8'(MC_DIV - 1))
    else $error("machine cycle period wrong");
  // no mode may step the counter between ticks
  a_inc_on_tick: assert property (
    inc |-> mc)
    else $error("count step off the tick");
  // rollover raises the overflow request and its status copy
  a_ovf_sets_flag: assert property (
    inc && s.cnt == 16'hFFFF |=> s.irqc[6] && s.sts[0])
    else $error("overflow did not set flag");
  // without reload a rollover wraps to zero
  a_ovf_zero: assert property (
    inc && s.cnt == 16'hFFFF && !s.ctl[4] && !s.aw && !s.ld_pend
    |=> s.cnt == 16'h0000)
    else $error("rollover did not wrap");
  // reload on overflow replaces the zero in the same tick
  a_ovf_reload: assert property (
    inc && s.cnt == 16'hFFFF && s.ctl[4:3] == 2'h2 && !s.aw &&
    !s.ld_pend |=> s.cnt == $past(s.rld))
    else $error("overflow reload missing");
  // no input selected: the count must not move
  a_stop_holds: assert property (
    mc && s.ctl[1:0] == 2'h0 && !s.aw && !s.ld_pend
    |=> s.cnt == $past(s.cnt))
    else $error("stopped counter moved");
  // prescaled timer skips every other tick
  a_prescale_skip: assert property (
    mc && s.ctl[1:0] == 2'h1 && s.ctl[7] && !s.pre && !s.aw &&
    !s.ld_pend |=> $stable(s.cnt))
    else $error("prescaled timer counted too fast");
  // plain timer steps on every tick
  a_timer_step: assert property (
    mc && s.ctl[1:0] == 2'h1 && !s.ctl[7] && s.cnt != 16'hFFFF &&
    !s.aw && !s.ld_pend |=> s.cnt == $past(s.cnt) + 16'h0001)
    else $error("timer missed a step");
  // gated timer holds while the sampled gate is low
  a_gate_low: assert property (
    mc && s.ctl[1:0] == 2'h3 && !s.g_smp && !s.aw && !s.ld_pend
    |=> $stable(s.cnt))
    else $error("gated timer counted with gate low");
  // gated timer steps while the sampled gate is high
  a_gate_count: assert property (
    mc && s.ctl[1:0] == 2'h3 && s.g_smp && !s.ctl[7] &&
    s.cnt != 16'hFFFF && !s.aw && !s.ld_pend
    |=> s.cnt == $past(s.cnt) + 16'h0001)
    else $error("gated timer missed a step");
  // a high-then-low pair of samples adds exactly one
  a_event_step: assert property (
    mc && s.ctl[1:0] == 2'h2 && s.g_prv && !s.g_smp &&
    s.cnt != 16'hFFFF && !s.aw && !s.ld_pend
    |=> s.cnt == $past(s.cnt) + 16'h0001)
    else $error("event not counted");
  // any other pair of samples leaves the event count alone
  a_event_hold: assert property (
    mc && s.ctl[1:0] == 2'h2 && !(s.g_prv && !s.g_smp) &&
    !s.aw && !s.ld_pend |=> $stable(s.cnt))
    else $error("event count moved without a fall");
  // a detected trigger fall always arms the pending load
  a_pend_set: assert property (
    t_fall |=> s.ld_pend)
    else $error("trigger fall not remembered");
  // the pending load lands at the following tick
  a_ext_reload: assert property (
    t_fall ##1 (!mc && !s.aw)[*1] ##0 s.ld_pend
    |-> ##[1:12] (mc && s.ld_pend && !s.aw) ##1
    s.cnt == $past(s.rld))
    else $error("trigger reload not applied");
  // an enabled trigger fall raises the reload request
  a_xflag_set: assert property (
    ev_xrl |=> s.irqc[7] && s.sts[1])
    else $error("reload flag not set");
  // the reload request only rises with its enable set
  a_xflag_gate: assert property (
    $rose(s.irqc[7]) && !$past(s.aw) |-> $past(s.ienb[3]))
    else $error("reload flag set while disabled");
  // a disabled trigger fall leaves the request untouched
  a_xflag_off: assert property (
    t_fall && !s.ienb[3] && !s.aw |=> s.irqc[7] == $past(s.irqc[7]))
    else $error("reload flag moved while disabled");
  // an enabled pending reload event drives the interrupt line
  a_irq_level: assert property (
    s.sts[1] && s.ien[1] |-> irq)
    else $error("interrupt missing for reload event");
  // only software may take the overflow request down
  a_ovf_sticky: assert property (
    s.irqc[6] && !s.aw |=> s.irqc[6])
    else $error("overflow flag cleared by hardware");
  // a clear write drops the chosen status bits when no set collides
  a_clr_status: assert property (
    s.aw && s.aidx == 8'hD2 && !ev_ovf && !ev_xrl && !cap_ev
    |=> (s.sts & $past(wd[2:0])) == 3'h0)
    else $error("status clear lost");
  // compare mode pin follows its control bit
  a_cmode_pin: assert property (
    compare_mode == s.ctl[2])
    else $error("compare mode pin wrong");
  // capture copies the live count and raises its status bit
  a_capture: assert property (
    cap_ev && !s.aw |=> s.rld == $past(s.cnt) && s.sts[2])
    else $error("capture missed");
  // software writes load the count bytes directly
  a_cnt_write: assert property (
    s.aw && s.aidx == 8'hCC |=> s.cnt[7:0] == $past(hwdata[7:0]))
    else $error("count low write lost");
  a_cnt_high: assert property (
    s.aw && s.aidx == 8'hCD |=> s.cnt[15:8] == $past(hwdata[7:0]))
    else $error("count high write lost");
  // a count read returns the count of its address phase
  a_rd_live: assert property (
    hsel && htrans[1] && hready && !hwrite && haddr[9:2] == 8'hCC
    |=> hrdata[7:0] == $past(s.cnt[7:0]))
    else $error("count read not live");
  // read data stands until the next read address phase
  a_rdata_hold: assert property (
    !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");

  // main scenarios worth seeing at least once
  c_timer: cover property (inc && s.ctl[1:0] == 2'h1);
  c_ovf_reload: cover property (
    inc && s.cnt == 16'hFFFF && s.ctl[4:3] == 2'h2);
  c_ext_reload: cover property (mc && s.ld_pend);
  c_capture: cover property (cap_ev);
  c_event: cover property (inc && s.ctl[1:0] == 2'h2);
endmodule // tcr_timer

// *** shared/tcr_pkg.sv ***
// constants, register map and types of the reloadable 16-bit timer/counter
package tcr_pkg;
  // machine cycle: oscillator (core_clk) periods per count tick
  localparam int unsigned MC_DIV = 12;
  localparam int unsigned DIV_W = 4;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_IRQC = 8'hC0;
  localparam logic [7:0] IDX_CCAP = 8'hC1;
  localparam logic [7:0] IDX_CC1L = 8'h00_C2;
  localparam logic [7:0] IDX_CC1H = 8'h00_C3;
  localparam logic [7:0] IDX_CC2L = 8'h00_C4;
  localparam logic [7:0] IDX_CC2H = 8'h00_C5;
  localparam logic [7:0] IDX_CC3L = 8'h00_C6;
  localparam logic [7:0] IDX_CC3H = 8'h00_C7;
  localparam logic [7:0] IDX_CTL = 8'h00_C8;
  localparam logic [7:0] IDX_RLDL = 8'h00_CA;
  localparam logic [7:0] IDX_RLDH = 8'h00_CB;
  localparam logic [7:0] IDX_CNTL = 8'h00_CC;
  localparam logic [7:0] IDX_CNTH = 8'h00_CD;
  localparam logic [7:0] IDX_IENB = 8'h00_D0;
  localparam logic [7:0] IDX_STAT = 8'h00_D1;
  localparam logic [7:0] IDX_ICLR = 8'h00_D2;
  localparam logic [7:0] IDX_IEN = 8'h00_D3;
  // counter_control field positions
  localparam int unsigned CTL_IS_LO = 0;
  localparam int unsigned CTL_IS_HI = 1;
  localparam int unsigned CTL_CM = 2;
  localparam int unsigned CTL_RS_LO = 3;
  localparam int unsigned CTL_RS_HI = 4;
  localparam int unsigned CTL_EDGE = 6;
  localparam int unsigned CTL_PS = 7;
  // interrupt_request_control flag positions
  localparam int unsigned IRC_OVF = 6;
  localparam int unsigned IRC_XRL = 7;
  // interrupt_enable_reg_b: external reload flag enable
  localparam int unsigned IENB_XEN = 3;
  // status / clear / enable bit positions
  localparam int unsigned ST_OVF = 0;
  localparam int unsigned ST_XRL = 1;
  localparam int unsigned ST_CAP = 2;
  // channel-0 capture selection in compare_capture_enable[1:0]
  localparam logic [1:0] CAP_SEL = 2'h1;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // pins arriving from outside, asynchronous to core_clk
  typedef struct packed {
    logic gate;
    logic trig;
    logic ch0;
  } tcr_pins_t;
  // whole state of the block
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic pre;
    logic [1:0] g_sync;
    logic [1:0] t_sync;
    logic [1:0] c_sync;
    logic g_smp, g_prv, t_smp, t_prv, c_smp, c_prv;
    logic ld_pend;
    logic [15:0] cnt, rld, cc1, cc2, cc3;
    logic [7:0] ctl, ccap, irqc, ienb;
    logic [2:0] sts, ien;
    logic aw;
    logic [7:0] aidx;
    logic [31:0] rdata;
  } tcr_st_t;
endpackage

// *** test/tcr_pin_model.sv ***
// pin model: drives the count/gate, reload trigger and channel-0 pins
`timescale 1ns/100ps
module tcr_pin_model #(
  parameter int HOLD = 16
) (
  input wire logic core_clk,
  output tcr_pkg::tcr_pins_t pins
);
  // idle levels: gate low, trigger high so that a fall is an edge
  initial pins = '{gate: 1'b0, trig: 1'b1, ch0: 1'b0};
  // every level stays over a full machine cycle, or it may be missed
  task automatic hold_lvl;
    repeat (HOLD) @(posedge core_clk);
  endtask
  // n high-then-low pulses on the count pin
  task automatic events(input int n);
    repeat (n) begin
      pins.gate <= 1'b1;
      hold_lvl();
      pins.gate <= 1'b0;
      hold_lvl();
    end
  endtask
  // one falling edge on the reload trigger, then back to idle
  task automatic fall_trig;
    pins.trig <= 1'b0;
    hold_lvl();
    pins.trig <= 1'b1;
    hold_lvl();
  endtask
  // steady level on the count/gate pin, for the gated timer
  task automatic set_gate(input logic v);
    pins.gate <= v;
    hold_lvl();
  endtask
  // new level on the channel-0 pin
  task automatic set_ch0(input logic v);
    pins.ch0 <= v;
    hold_lvl();
  endtask
endmodule  // tcr_pin_model

// *** test/tcr_timer_tb.sv ***
// self-checking bench for the reloadable 16-bit timer/counter
`timescale 1ns/100ps
module tcr_timer_tb;
  localparam int unsigned MC = 4;  // short machine cycle keeps runs brief
  localparam logic [7:0] OVF = 8'h01 << tcr_pkg::IRC_OVF;
  localparam logic [7:0] XRL = 8'h01 << tcr_pkg::IRC_XRL;
  logic core_clk, reset, hsel, hwrite, hready, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic compare_mode, irq;
  logic rd_dp;  // a read data phase is on the bus
  tcr_pkg::tcr_pins_t pins;
  int err_count, samples_checked;
  logic [31:0] exp_q[$];  // expected read data, oldest first
  logic [15:0] r;
  logic [7:0] a, d;
  assign hready = hreadyout;  // the one slave drives bus ready
  tcr_timer #(.MC_DIV(MC)) uut (.core_clk(core_clk), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins),
    .compare_mode(compare_mode), .irq(irq));
  tcr_pin_model #(.HOLD(4 * MC)) pm (.core_clk(core_clk), .pins(pins));
  // free-running 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // compare seen against expected, count both outcomes
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // counts, verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // single write; one idle edge after so a read sees the new value
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    haddr <= {2'($urandom()), idx, 2'b00};
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'($urandom()), v};
    do @(posedge core_clk); while (hready !== 1'b1);
    @(posedge core_clk);
  endtask
  // single read; the expectation goes on the queue for the monitor
  task automatic rd(input logic [7:0] idx, input logic [7:0] v);
    exp_q.push_back({24'h00_0000, v});
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= 1'b0;
    haddr <= {2'($urandom()), idx, 2'b00};
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    rd_dp <= 1'b1;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd_dp <= 1'b0;
  endtask
  // read data is taken at the edge that ends its data phase
  always @(posedge core_clk)
    if (rd_dp && hready === 1'b1) begin
      check(hrdata, exp_q.pop_front());
      check({31'h0, hresp}, 32'h0000_0000);
    end
  // watchdog: the tests need a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    end_sim();
  end
  // main sequence
  initial begin
    void'($urandom(32'hf671_83a2));
    {hsel, hwrite, rd_dp} = 3'b000;
    htrans = 2'b00;
    haddr = 12'h000;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    reset = 1'b1;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    // storage and count bytes, the unmapped 0xC9 place reads zero
    for (int i = 0; i < 12; i++) begin
      a = tcr_pkg::IDX_CC1L + 8'(i);
      if (a == tcr_pkg::IDX_CTL) continue;
      d = 8'($urandom());
      wr(a, d);
      rd(a, (a == 8'hC9) ? 8'h00 : d);
    end
    wr(tcr_pkg::IDX_STAT, 8'h07);
    rd(tcr_pkg::IDX_STAT, 8'h00);
    wr(tcr_pkg::IDX_CTL, 8'h04);
    check({31'h0, compare_mode}, 32'h0000_0001);
    wr(tcr_pkg::IDX_CTL, 8'h00);
    check({31'h0, compare_mode}, 32'h0000_0000);
    $display("test registers done");
    // stopped, event counting, gated timer with the gate low
    wr(tcr_pkg::IDX_CNTL, 8'h00);
    wr(tcr_pkg::IDX_CNTH, 8'h00);
    pm.events(2);
    rd(tcr_pkg::IDX_CNTL, 8'h00);
    wr(tcr_pkg::IDX_CTL, 8'h02);
    pm.events(5);
    rd(tcr_pkg::IDX_CNTL, 8'h05);
    wr(tcr_pkg::IDX_CTL, 8'h03);
    repeat (20 * MC) @(posedge core_clk);
    rd(tcr_pkg::IDX_CNTL, 8'h05);
    // 40 machine cycles of counting: N + 3 edges between the two writes
    wr(tcr_pkg::IDX_CTL, 8'h01);
    repeat (40 * MC - 3) @(posedge core_clk);
    wr(tcr_pkg::IDX_CTL, 8'h00);
    rd(tcr_pkg::IDX_CNTL, 8'h2D);
    wr(tcr_pkg::IDX_CTL, 8'h81);
    repeat (40 * MC - 3) @(posedge core_clk);
    wr(tcr_pkg::IDX_CTL, 8'h00);
    rd(tcr_pkg::IDX_CNTL, 8'h41);
    pm.set_gate(1'b1);
    wr(tcr_pkg::IDX_CTL, 8'h03);
    repeat (40 * MC - 3) @(posedge core_clk);
    wr(tcr_pkg::IDX_CTL, 8'h00);
    rd(tcr_pkg::IDX_CNTL, 8'h69);
    pm.set_gate(1'b0);
    $display("test counting done");
    // rollover reloads, sets the overflow flag, irq follows enable
    r = 16'($urandom()) | 16'h0080;  // low byte never equals 0x05
    wr(tcr_pkg::IDX_CTL, 8'h00);
    wr(tcr_pkg::IDX_RLDL, r[7:0]);
    wr(tcr_pkg::IDX_RLDH, r[15:8]);
    wr(tcr_pkg::IDX_CNTL, 8'hFF);
    wr(tcr_pkg::IDX_CNTH, 8'hFF);
    wr(tcr_pkg::IDX_CTL, 8'h12);
    pm.events(1);
    rd(tcr_pkg::IDX_CNTL, r[7:0]);
    rd(tcr_pkg::IDX_CNTH, r[15:8]);
    rd(tcr_pkg::IDX_IRQC, OVF);
    rd(tcr_pkg::IDX_STAT, 8'h01);
    check({31'h0, irq}, 32'h0000_0000);
    wr(tcr_pkg::IDX_IEN, 8'h07);
    check({31'h0, irq}, 32'h0000_0001);
    wr(tcr_pkg::IDX_ICLR, 8'h01);
    check({31'h0, irq}, 32'h0000_0000);
    rd(tcr_pkg::IDX_IRQC, OVF);
    wr(tcr_pkg::IDX_IRQC, 8'h00);
    rd(tcr_pkg::IDX_IRQC, 8'h00);
    $display("test overflow done");
    // trigger reload, flag only with its enable, no reload when off
    wr(tcr_pkg::IDX_IENB, 8'h08);
    wr(tcr_pkg::IDX_CTL, 8'h1A);
    wr(tcr_pkg::IDX_CNTL, 8'h05);
    pm.fall_trig();
    rd(tcr_pkg::IDX_CNTL, r[7:0]);
    rd(tcr_pkg::IDX_IRQC, XRL);
    check({31'h0, irq}, 32'h0000_0001);
    wr(tcr_pkg::IDX_ICLR, 8'h02);
    wr(tcr_pkg::IDX_IRQC, 8'h00);
    wr(tcr_pkg::IDX_IENB, 8'h00);
    wr(tcr_pkg::IDX_CNTL, 8'h05);
    pm.fall_trig();
    rd(tcr_pkg::IDX_CNTL, r[7:0]);
    rd(tcr_pkg::IDX_IRQC, 8'h00);
    check({31'h0, irq}, 32'h0000_0000);
    wr(tcr_pkg::IDX_CTL, 8'h0A);
    wr(tcr_pkg::IDX_CNTL, 8'h05);
    pm.fall_trig();
    rd(tcr_pkg::IDX_CNTL, 8'h05);
    $display("test trigger done");
    // capture into the reload register on the selected edge only
    wr(tcr_pkg::IDX_CCAP, 8'h01);
    wr(tcr_pkg::IDX_CTL, 8'h40);
    wr(tcr_pkg::IDX_CNTL, 8'h42);
    pm.set_ch0(1'b1);
    wr(tcr_pkg::IDX_CNTL, 8'h55);
    pm.set_ch0(1'b0);
    rd(tcr_pkg::IDX_RLDL, 8'h42);
    wr(tcr_pkg::IDX_CTL, 8'h00);
    wr(tcr_pkg::IDX_CNTL, 8'h37);
    pm.set_ch0(1'b1);
    wr(tcr_pkg::IDX_CNTL, 8'h38);
    pm.set_ch0(1'b0);
    rd(tcr_pkg::IDX_RLDL, 8'h38);
    $display("test capture done");
    end_sim();
  end
endmodule  // tcr_timer_tb
